// File: verilog/tcio_top.v
// Purpose: channel 4 pin control, four capture/compare functions
// Assumes: counter and match strobes come from the timer core
// Notes: registers reached over axi4-lite; unmapped access gives slverr
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tcio_regs.vh"
// Summary of operation
// - high control bits 7..4 select general register B function
// - high control bits 3..0 select general register A function
// - low control bits 7..4 select general register D function
// - low control bits 3..0 select general register C function
// - compare code x01: pin driven low on match, bit 2 initial level
// - compare code x10: pin driven high on match, bit 2 initial level
// - compare code x11: pin toggles on match from bit 2 level
// - capture code 1x00: latch counter on rising pin edge
// - capture code 1x01: latch counter on falling pin edge
// - capture code 1x10: latch counter on both pin edges
// - buffer B mode set: D field void, no events on D
// - buffer A mode set: C field void, no events on C
module tcio_top #(
   parameter CNT_W = 16
) (
   // clock, reset, enable
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // axi4-lite write
   input wire [3:0] s_awaddr,
   input wire s_awvalid,
   output wire s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output wire s_wready,
   output wire [1:0] s_bresp,
   output wire s_bvalid,
   input wire s_bready,
   // axi4-lite read
   input wire [3:0] s_araddr,
   input wire s_arvalid,
   output wire s_arready,
   output wire [31:0] s_rdata,
   output wire [1:0] s_rresp,
   output wire s_rvalid,
   input wire s_rready,
   // timer core
   input wire [CNT_W-1:0] counter,
   input wire [3:0] compare_match,
   output wire [4*CNT_W-1:0] capture_value,
   output wire [3:0] capture_strobe,
   // channel pins a, b, c, d in bits 0..3
   input wire [3:0] chan_pin_in,
   output wire [3:0] chan_pin_out,
   output wire [3:0] chan_pin_oe
);
   reg [7:0] chan4_io_ctrl_high;
   reg [7:0] chan4_io_ctrl_low;
   reg [7:0] chan4_mode_reg;
   wire wr_en;
   wire [3:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire [3:0] rd_addr;
   reg [31:0] rd_data;
   reg [1:0] rd_resp;
   reg [1:0] wr_resp;
   wire buffer_mode_a;
   wire buffer_mode_b;
   wire [3:0] func_sel_a;
   wire [3:0] func_sel_b;
   wire [3:0] func_sel_c;
   wire [3:0] func_sel_d;
   wire [3:0] suppress;

   // address is mapped when it hits one of the four words
   function mapped;
      input [3:0] addr;
      begin
         mapped = addr == `TCIO_OFS_CTRL_HIGH || addr == `TCIO_OFS_CTRL_LOW
            || addr == `TCIO_OFS_MODE || addr == `TCIO_OFS_PINS;
      end
   endfunction

   tcio_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .s_awaddr(s_awaddr),
      .s_awvalid(s_awvalid),
      .s_awready(s_awready),
      .s_wdata(s_wdata),
      .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid),
      .s_wready(s_wready),
      .s_bresp(s_bresp),
      .s_bvalid(s_bvalid),
      .s_bready(s_bready),
      .s_araddr(s_araddr),
      .s_arvalid(s_arvalid),
      .s_arready(s_arready),
      .s_rdata(s_rdata),
      .s_rresp(s_rresp),
      .s_rvalid(s_rvalid),
      .s_rready(s_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_resp(wr_resp),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_resp(rd_resp)
   );

   // register writes; only byte lane 0 carries data, fields reset to 0000
   always @(posedge aclk) begin
      if (!aresetn) begin
         chan4_io_ctrl_high <= `TCIO_CTRL_RST;
         chan4_io_ctrl_low <= `TCIO_CTRL_RST;
         chan4_mode_reg <= `TCIO_MODE_RST;
      end else if (clk_en && wr_en && wr_strb[0]) begin
         if (wr_addr == `TCIO_OFS_CTRL_HIGH) begin
            chan4_io_ctrl_high <= wr_data[7:0];
         end else if (wr_addr == `TCIO_OFS_CTRL_LOW) begin
            chan4_io_ctrl_low <= wr_data[7:0];
         end else if (wr_addr == `TCIO_OFS_MODE) begin
            chan4_mode_reg <= wr_data[7:0];
         end
      end
   end

   // write response: the pin status word is read-only but answers okay
   always @* begin
      if (mapped(wr_addr)) begin
         wr_resp = `TCIO_RESP_OKAY;
      end else begin
         wr_resp = `TCIO_RESP_SLVERR;
      end
   end

   // read decode; upper bits read as zero
   always @* begin
      rd_data = 32'h00000000;
      rd_resp = `TCIO_RESP_OKAY;
      if (rd_addr == `TCIO_OFS_CTRL_HIGH) begin
         rd_data = {24'h000000, chan4_io_ctrl_high};
      end else if (rd_addr == `TCIO_OFS_CTRL_LOW) begin
         rd_data = {24'h000000, chan4_io_ctrl_low};
      end else if (rd_addr == `TCIO_OFS_MODE) begin
         rd_data = {24'h000000, chan4_mode_reg};
      end else if (rd_addr == `TCIO_OFS_PINS) begin
         rd_data = {20'h00000, chan_pin_oe, chan_pin_out, chan_pin_in};
      end else begin
         rd_resp = `TCIO_RESP_SLVERR;
      end
   end

   // field split
   assign func_sel_b =
      chan4_io_ctrl_high[`TCIO_FLD_HI_MSB:`TCIO_FLD_HI_LSB];
   assign func_sel_a =
      chan4_io_ctrl_high[`TCIO_FLD_LO_MSB:`TCIO_FLD_LO_LSB];
   assign func_sel_d =
      chan4_io_ctrl_low[`TCIO_FLD_HI_MSB:`TCIO_FLD_HI_LSB];
   assign func_sel_c =
      chan4_io_ctrl_low[`TCIO_FLD_LO_MSB:`TCIO_FLD_LO_LSB];

   // buffer modes steal c and d; their fields then do nothing
   assign buffer_mode_a = chan4_mode_reg[`TCIO_MODE_BUF_A];
   assign buffer_mode_b = chan4_mode_reg[`TCIO_MODE_BUF_B];
   assign suppress = {buffer_mode_b, buffer_mode_a, 2'b00};

   tcio_pin_unit #(.CNT_W(CNT_W)) u_pin_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .func_sel(func_sel_a),
      .suppress(suppress[0]),
      .counter(counter),
      .compare_match(compare_match[0]),
      .pin_in(chan_pin_in[0]),
      .pin_out(chan_pin_out[0]),
      .pin_oe(chan_pin_oe[0]),
      .capture_value(capture_value[CNT_W-1:0]),
      .capture_strobe(capture_strobe[0])
   );
   tcio_pin_unit #(.CNT_W(CNT_W)) u_pin_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .func_sel(func_sel_b),
      .suppress(suppress[1]),
      .counter(counter),
      .compare_match(compare_match[1]),
      .pin_in(chan_pin_in[1]),
      .pin_out(chan_pin_out[1]),
      .pin_oe(chan_pin_oe[1]),
      .capture_value(capture_value[2*CNT_W-1:CNT_W]),
      .capture_strobe(capture_strobe[1])
   );
   tcio_pin_unit #(.CNT_W(CNT_W)) u_pin_c (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .func_sel(func_sel_c),
      .suppress(suppress[2]),
      .counter(counter),
      .compare_match(compare_match[2]),
      .pin_in(chan_pin_in[2]),
      .pin_out(chan_pin_out[2]),
      .pin_oe(chan_pin_oe[2]),
      .capture_value(capture_value[3*CNT_W-1:2*CNT_W]),
      .capture_strobe(capture_strobe[2])
   );
   tcio_pin_unit #(.CNT_W(CNT_W)) u_pin_d (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .func_sel(func_sel_d),
      .suppress(suppress[3]),
      .counter(counter),
      .compare_match(compare_match[3]),
      .pin_in(chan_pin_in[3]),
      .pin_out(chan_pin_out[3]),
      .pin_oe(chan_pin_oe[3]),
      .capture_value(capture_value[4*CNT_W-1:3*CNT_W]),
      .capture_strobe(capture_strobe[3])
   );
endmodule // tcio_top
`default_nettype wire

// File: verilog/tcio_regs.vh
// Purpose: constants for the channel 4 capture/compare pin control block
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: one aligned word per register, data in the low bits
`ifndef TCIO_REGS_VH
`define TCIO_REGS_VH
// register byte offsets
`define TCIO_OFS_CTRL_HIGH 4'h0
`define TCIO_OFS_CTRL_LOW 4'h4
`define TCIO_OFS_MODE 4'h8
`define TCIO_OFS_PINS 4'hC
// field layout
`define TCIO_FIELD_W 4
`define TCIO_FLD_HI_MSB 7
`define TCIO_FLD_HI_LSB 4
`define TCIO_FLD_LO_MSB 3
`define TCIO_FLD_LO_LSB 0
`define TCIO_BIT_CAPT 3
`define TCIO_BIT_INIT 2
// mode register bits
`define TCIO_MODE_BUF_A 4
`define TCIO_MODE_BUF_B 5
// reset values
`define TCIO_CTRL_RST 8'h00
`define TCIO_MODE_RST 8'h00
`define TCIO_FIELD_RST 4'h0
// action codes (low two field bits)
`define TCIO_ACT_NONE 2'h0
`define TCIO_ACT_LOW 2'h1
`define TCIO_ACT_HIGH 2'h2
`define TCIO_ACT_TOGGLE 2'h3
// capture edge codes
`define TCIO_EDGE_RISE 2'h0
`define TCIO_EDGE_FALL 2'h1
`define TCIO_EDGE_BOTH 2'h2
// axi responses
`define TCIO_RESP_OKAY 2'h0
`define TCIO_RESP_SLVERR 2'h2
`endif

// File: verilog/tcio_pin_unit.v
// Purpose: one general register's pin function, compare output or capture
// Assumes: pin input synchronous to aclk, match strobe is one cycle
// Notes: field change to a compare code reloads the initial pin level
`timescale 1ns/1ns
`default_nettype none
`include "tcio_regs.vh"
module tcio_pin_unit #(
   parameter CNT_W = 16
) (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // control
   input wire [3:0] func_sel,
   input wire suppress,
   // timer side
   input wire [CNT_W-1:0] counter,
   input wire compare_match,
   // pin
   input wire pin_in,
   output reg pin_out,
   output reg pin_oe,
   // capture result
   output reg [CNT_W-1:0] capture_value,
   output reg capture_strobe
);
   reg pin_prev;
   reg [3:0] sel_prev;
   wire is_capt;
   wire [1:0] act;
   wire rise;
   wire fall;
   reg hit;
   assign is_capt = func_sel[`TCIO_BIT_CAPT];
   assign act = func_sel[1:0];
   assign rise = pin_in & ~pin_prev;
   assign fall = ~pin_in & pin_prev;
   // edge select; code 11 is taken as no capture
   always @* begin
      case (act)
         `TCIO_EDGE_RISE: hit = rise;
         `TCIO_EDGE_FALL: hit = fall;
         `TCIO_EDGE_BOTH: hit = rise | fall;
         default: hit = 1'b0;
      endcase
   end
   // pin driver and capture latch; suppress blocks all events
   always @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= 1'b0;
         pin_oe <= 1'b0;
         pin_prev <= 1'b0;
         sel_prev <= `TCIO_FIELD_RST;
         capture_value <= {CNT_W{1'b0}};
         capture_strobe <= 1'b0;
      end else if (clk_en) begin
         pin_prev <= pin_in;
         sel_prev <= func_sel;
         capture_strobe <= 1'b0;
         // disabled output for codes x00 in compare mode
         pin_oe <= !is_capt && act != `TCIO_ACT_NONE && !suppress;
         if (is_capt) begin
            if (hit && !suppress) begin
               capture_value <= counter;
               capture_strobe <= 1'b1;
            end
         end else if (func_sel != sel_prev) begin
            pin_out <= func_sel[`TCIO_BIT_INIT]; // initial level
         end else if (compare_match && !suppress) begin
            case (act)
               `TCIO_ACT_LOW: pin_out <= 1'b0;
               `TCIO_ACT_HIGH: pin_out <= 1'b1;
               `TCIO_ACT_TOGGLE: pin_out <= ~pin_out;
               default: pin_out <= pin_out;
            endcase
         end
      end
   end
endmodule // tcio_pin_unit
`default_nettype wire

// File: verilog/tcio_axil_slave.v
// Purpose: axi4-lite slave front end, one write and one read at a time
// Assumes: 32-bit data, 4-bit byte address
// Notes: aw and w are taken in any order; response two cycles after both
`timescale 1ns/1ns
`default_nettype none
module tcio_axil_slave (
   // clock
   input wire aclk,
   input wire aresetn,
   input wire clk_en,
   // write address and data
   input wire [3:0] s_awaddr,
   input wire s_awvalid,
   output wire s_awready,
   input wire [31:0] s_wdata,
   input wire [3:0] s_wstrb,
   input wire s_wvalid,
   output wire s_wready,
   output reg [1:0] s_bresp,
   output reg s_bvalid,
   input wire s_bready,
   // read
   input wire [3:0] s_araddr,
   input wire s_arvalid,
   output wire s_arready,
   output reg [31:0] s_rdata,
   output reg [1:0] s_rresp,
   output reg s_rvalid,
   input wire s_rready,
   // register file side
   output reg wr_en,
   output reg [3:0] wr_addr,
   output reg [31:0] wr_data,
   output reg [3:0] wr_strb,
   input wire [1:0] wr_resp,
   output wire [3:0] rd_addr,
   input wire [31:0] rd_data,
   input wire [1:0] rd_resp
);
   reg aw_held;
   reg w_held;
   // each channel ready while its item is not held and no response pending
   assign s_awready = clk_en && !aw_held && !s_bvalid;
   assign s_wready = clk_en && !w_held && !s_bvalid;
   assign s_arready = clk_en && !s_rvalid;
   assign rd_addr = s_araddr;
   // write path: collect address and data, then one write pulse
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 4'h0;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= 2'h0;
      end else if (clk_en) begin
         wr_en <= 1'b0;
         if (s_awvalid && s_awready) begin
            aw_held <= 1'b1;
            wr_addr <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_held <= 1'b1;
            wr_data <= s_wdata;
            wr_strb <= s_wstrb;
         end
         if (aw_held && w_held && !wr_en) begin
            wr_en <= 1'b1;
         end
         if (wr_en) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= wr_resp;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end
   // read path: data registered on address acceptance
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h00000000;
         s_rresp <= 2'h0;
      end else if (clk_en) begin
         if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rdata <= rd_data;
            s_rresp <= rd_resp;
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end
endmodule // tcio_axil_slave
`default_nettype wire

// File: testbench/tcio_monitor.sv
// Purpose: port checks for the channel pin control block
// Assumes: clk_en held high by the bench except in its freeze test
// Notes: bound to tcio_top below
`timescale 1ns/1ns
`default_nettype none
module tcio_monitor #(
   parameter CNT_W = 16
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic [1:0] s_bresp,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic s_rvalid,
   input wire logic s_rready,
   // timer and pins
   input wire logic [CNT_W-1:0] counter,
   input wire logic [3:0] compare_match,
   input wire logic [4*CNT_W-1:0] capture_value,
   input wire logic [3:0] capture_strobe,
   input wire logic [3:0] chan_pin_in,
   input wire logic [3:0] chan_pin_out,
   input wire logic [3:0] chan_pin_oe
);
   // one domain, so clock and reset are given once
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // answers stand until taken; the field write lands near bvalid
   a_bresp_hold: assert property (s_bvalid && !s_bready |=>
      s_bvalid && $stable(s_bresp)) else $error("bresp dropped early");
   a_rdata_hold: assert property (s_rvalid && !s_rready |=>
      s_rvalid && $stable(s_rdata)) else $error("rdata dropped early");
   a_write_answer: assert property (s_awvalid && s_awready && s_wvalid &&
      s_wready |-> ##[1:4] s_bvalid) else $error("no write answer");
   a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
      else $error("no read answer");
   a_ar_refused: assert property (s_rvalid |-> !s_arready)
      else $error("read taken while answer pending");
   a_cap_no_oe: assert property (
      (capture_strobe & chan_pin_oe) == 4'h0)
      else $error("capture on a driven pin");
   a_cap_edge: assert property (
      (capture_strobe & ~($past(chan_pin_in) ^ $past(chan_pin_in, 2)))
      == 4'h0) else $error("capture without edge");
   a_cap_value_a: assert property (
      capture_strobe[0] |-> capture_value[CNT_W-1:0] == $past(counter))
      else $error("A capture value wrong");
   a_cap_value_d: assert property (
      capture_strobe[3] |-> capture_value[4*CNT_W-1:3*CNT_W] ==
      $past(counter)) else $error("D capture value wrong");
   a_pin_cause: assert property (
      |((chan_pin_out ^ $past(chan_pin_out)) & ~$past(compare_match)) |->
      s_bvalid || $past(s_bvalid))
      else $error("pin moved without match or write");
   a_oe_cause: assert property ($changed(chan_pin_oe) |->
      s_bvalid || $past(s_bvalid)) else $error("enable moved without write");
endmodule // tcio_monitor

bind tcio_top tcio_monitor #(.CNT_W(CNT_W)) u_mon (.aclk(aclk),
   .aresetn(aresetn), .s_awvalid(s_awvalid), .s_awready(s_awready),
   .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
   .s_bvalid(s_bvalid), .s_bready(s_bready), .s_arvalid(s_arvalid),
   .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid),
   .s_rready(s_rready), .counter(counter), .compare_match(compare_match),
   .capture_value(capture_value), .capture_strobe(capture_strobe),
   .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
   .chan_pin_oe(chan_pin_oe));
`default_nettype wire

// File: testbench/tcio_pin_model.sv
// Purpose: far side of the four channel pins
// Assumes: the bench moves the external level just after an edge
// Notes: no pull; an undriven capture pin shows the external level
`timescale 1ns/1ns
`default_nettype none
module tcio_pin_model (
   // block side
   input wire logic [3:0] pin_out,
   input wire logic [3:0] pin_oe,
   // external source level
   input wire logic [3:0] ext_level,
   // resolved wire
   output wire logic [3:0] pin_wire
);
   // the driving block wins, so a compare pin never fights the source
   assign pin_wire = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // tcio_pin_model
`default_nettype wire

// File: testbench/tcio_tb_top.sv
// Purpose: self-checking bench for the channel pin control block
// Assumes: clk_en held high except in the freeze test, fixed seed
// Notes: every compare code swept on every unit; capture edge codes 00, 01, 10 with random bit 2
`timescale 1ns/1ns
`default_nettype none
`include "tcio_regs.vh"
module tcio_tb_top;
   logic aclk, aresetn, clk_en, s_awvalid, s_wvalid, s_bready;
   logic s_arvalid, s_rready;
   logic [3:0] s_awaddr, s_araddr, s_wstrb, cmp, ext;
   logic [31:0] s_wdata, q;
   logic [15:0] counter;
   logic [1:0] r;
   wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   wire [1:0] s_bresp, s_rresp;
   wire [31:0] s_rdata;
   wire [63:0] cap_v;
   wire [3:0] cap_s, p_out, p_oe, p_wire;
   int bad_count, n_compared;

   tcio_top #(.CNT_W(16)) uut (.aclk(aclk), .aresetn(aresetn),
      .clk_en(clk_en), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
      .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
      .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
      .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
      .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
      .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
      .counter(counter), .compare_match(cmp), .capture_value(cap_v),
      .capture_strobe(cap_s), .chan_pin_in(p_wire), .chan_pin_out(p_out),
      .chan_pin_oe(p_oe));
   tcio_pin_model u_pins (.pin_out(p_out), .pin_oe(p_oe), .ext_level(ext),
      .pin_wire(p_wire));

   // 100 ns clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   // fresh counter value every cycle
   always @(posedge aclk) begin
      counter <= 16'($urandom);
   end

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask
   // readies sampled at the falling edge, so the rising edge sees no race
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bit aw, w, h;
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= {24'h0, d};
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      h = 1'b0;
      while (!h) begin
         @(negedge aclk);
         h = s_bvalid === 1'b1;
         r = s_bresp;
         aw = aw && s_awready !== 1'b1;
         w = w && s_wready !== 1'b1;
         @(posedge aclk);
         if (!aw) s_awvalid <= 1'b0;
         if (!w) s_wvalid <= 1'b0;
      end
      s_bready <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      bit ar, h;
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      ar = 1'b1;
      h = 1'b0;
      while (!h) begin
         @(negedge aclk);
         h = s_rvalid === 1'b1;
         q = s_rdata;
         r = s_rresp;
         ar = ar && s_arready !== 1'b1;
         @(posedge aclk);
         if (!ar) s_arvalid <= 1'b0;
      end
      s_rready <= 1'b0;
   endtask
   // field i: A, B in the high register, C, D in the low one
   task automatic fld(input int i, input logic [3:0] v);
      wr(i < 2 ? 4'h0 : 4'h4, {4'h0, v} << (i[0] ? 4 : 0));
   endtask
   task automatic pulse(input int i);
      @(posedge aclk);
      cmp[i] <= 1'b1;
      @(posedge aclk);
      cmp[i] <= 1'b0;
   endtask
   // a rising then a falling edge on pin i, strobes counted
   task automatic edges(input int i, output int s);
      s = 0;
      for (int e = 0; e < 2; e++) begin
         @(posedge aclk);
         ext[i] <= ~ext[i];
         repeat (4) begin
            @(negedge aclk);
            s += int'(cap_s[i]);
         end
      end
   endtask
   function automatic logic exp_pin(input logic [2:0] c, input int n);
      case (c[1:0])
         `TCIO_ACT_LOW: return 1'b0;
         `TCIO_ACT_HIGH: return 1'b1;
         `TCIO_ACT_TOGGLE: return c[2] ^ n[0];
         default: return c[2];
      endcase
   endfunction
   task automatic print_verdict();
      $display("counts: %0d compared, %0d mismatched", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // a hang ends the run as a failure
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      int n;
      logic [3:0] c;
      void'($urandom(50990));
      aresetn = 1'b0;
      clk_en = 1'b1;
      cmp = 4'h0;
      ext = 4'h0;
      s_awaddr = 4'h0;
      s_araddr = 4'h0;
      s_wdata = 32'h0;
      s_wstrb = 4'hF;
      s_awvalid = 1'b0;
      s_wvalid = 1'b0;
      s_bready = 1'b0;
      s_arvalid = 1'b0;
      s_rready = 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 12; a += 4) begin
         rd(4'(a));
         chk("reset reg", 0, q); // reset value
      end
      chk("reset oe", 0, p_oe);
      rd(4'h2);
      chk("unmapped rresp", `TCIO_RESP_SLVERR, r);
      wr(4'h6, 8'hFF);
      chk("unmapped bresp", `TCIO_RESP_SLVERR, r);
      wr(4'hC, 8'hFF);
      chk("status bresp", `TCIO_RESP_OKAY, r);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 8; k++) begin
            c = 4'(k);
            n = $urandom_range(3, 1);
            fld(i, 4'h0);
            fld(i, c);
            rd(i < 2 ? 4'h0 : 4'h4);
            chk("readback", {4'h0, c} << (i[0] ? 4 : 0),
               q);
            settle(2);
            chk("oe", c[1:0] != 2'h0, p_oe[i]);
            chk("initial level", c[2], p_out[i]);
            chk("other oe", 0, p_oe & ~(4'h1 << i));
            repeat (n) pulse(i);
            settle(2);
            chk("match level", exp_pin(c[2:0], n),
               p_out[i]);
         end
         // leave the unit disabled so it cannot drive during the next one
         fld(i, 4'h0);
      end
      $display("test compare done");
      wr(4'h0, 8'h00);
      wr(4'h4, 8'h00);
      settle(2);
      for (int i = 0; i < 4; i++) begin
         for (int k = 0; k < 3; k++) begin
            // codes ending in 11 are never written
            c = {1'b1, 1'($urandom), 2'(k)};
            fld(i, c);
            settle(2);
            chk("capture oe", 0, p_oe[i]);
            edges(i, n);
            chk("strobes", k == 2 ? 2 : 1, n);
         end
      end
      $display("test capture done");
      wr(4'h8, 8'h30);
      rd(4'h8);
      chk("mode reg", 32'h30, q);
      wr(4'h4, 8'h83);
      settle(2);
      chk("buffered oe", 0, p_oe[3:2]);
      pulse(2);
      settle(2);
      chk("buffered match", 0, p_out[2]);
      edges(3, n);
      chk("buffered capture", 0, n);
      wr(4'h8, 8'h00);
      settle(2);
      chk("unbuffered oe", 4'h4, p_oe);
      edges(3, n);
      chk("unbuffered capture", 1, n);
      $display("test buffer done");
      // enable low freezes the toggle unit; a second match then lands
      @(posedge aclk);
      clk_en <= 1'b0;
      pulse(2);
      settle(2);
      chk("frozen match", 0, p_out[2]);
      clk_en <= 1'b1;
      pulse(2);
      settle(2);
      chk("thawed match", 1, p_out[2]);
      $display("test freeze done");
      print_verdict();
   end
endmodule // tcio_tb_top
`default_nettype wire
